// ---- shared/cdd_pkg.sv ----
// package: register map, field layout, sizes and carrier types of the decoder
package cdd_pkg;

  // ==========================================================================
  // register map (byte addresses, one aligned word each)
  localparam int CDD_ADDR_W = 8;
  localparam logic [7:0] CDD_SUBQ_STATUS_REG   = 8'h00;
  localparam logic [7:0] CDD_SUBQ_BYTE_REG     = 8'h04;
  localparam logic [7:0] CDD_SUBQ_RELEASE_REG  = 8'h08;
  localparam logic [7:0] CDD_TEXT_CTRL_REG     = 8'h0C;
  localparam logic [7:0] CDD_TEXT_STATUS_REG   = 8'h10;
  localparam logic [7:0] CDD_TEXT_BYTE_REG     = 8'h14;
  localparam logic [7:0] CDD_TEXT_RELEASE_REG  = 8'h18;
  localparam logic [7:0] CDD_IRQ_ENABLE_REG_A  = 8'h1C;
  localparam logic [7:0] CDD_IRQ_ENABLE_REG_B  = 8'h20;
  localparam logic [7:0] CDD_DECODE_MODE_REG   = 8'h24;
  localparam logic [7:0] CDD_FIFO_LEVEL_REG    = 8'h28;

  // ==========================================================================
  // field positions and response codes
  localparam int CDD_READY_BIT   = 0;
  localparam int CDD_LOCKED_BIT  = 1;
  localparam int CDD_CRC_BIT     = 2;
  localparam int CDD_FREEZE_BIT  = 0;
  localparam int CDD_PASS_BIT    = 1;
  localparam int CDD_OVERRUN_BIT = 0;
  localparam int CDD_IRQ_EN_BIT  = 0;
  localparam int CDD_PLAY_BIT    = 0;
  localparam logic [1:0] CDD_RESP_OKAY   = 2'h0;
  localparam logic [1:0] CDD_RESP_SLVERR = 2'h2;

  // ==========================================================================
  // sizes
  localparam int CDD_SUBQ_BYTES   = 10;
  localparam int CDD_TEXT_BYTES   = 16;
  localparam int CDD_FRAME_BYTES  = 24;
  localparam int CDD_LAT_FRAMES   = 118;
  localparam int CDD_FIFO_FRAMES  = 128;
  localparam int CDD_C1_MAX_ERR   = 2;
  localparam int CDD_C2_MAX_ERR   = 2;
  localparam int CDD_C2_MAX_ERAS  = 4;
  localparam int CDD_SQI_W        = 4;
  localparam int CDD_TXI_W        = 5;
  localparam int CDD_FRM_W        = 7;
  localparam int CDD_BYT_W        = 5;
  localparam int CDD_FILL_W       = 8;

  // ==========================================================================
  // types
  typedef enum logic {CDD_FLUSH, CDD_PLAY} cdd_mode_e;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       last;
    logic       crc_ok;
  } cdd_sym_in_s;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       last;
    logic [2:0] c1_errs;
    logic [2:0] c2_errs;
    logic [2:0] c2_eras;
  } cdd_data_in_s;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       erasure;
  } cdd_audio_out_s;

  typedef struct packed {
    logic                                 awready;
    logic                                 wready;
    logic                                 bvalid;
    logic [1:0]                           bresp;
    logic                                 aw_got;
    logic                                 w_got;
    logic [CDD_ADDR_W-1:0]                awaddr;
    logic [31:0]                          wdata;
    logic                                 wstrb0;
    logic                                 arready;
    logic                                 rvalid;
    logic [1:0]                           rresp;
    logic [31:0]                          rdata;
    logic [CDD_SUBQ_BYTES-1:0][7:0]       subq_shadow;
    logic [CDD_SUBQ_BYTES-1:0][7:0]       subq_held;
    logic [CDD_SQI_W-1:0]                 subq_rx_idx;
    logic [CDD_SQI_W-1:0]                 subq_rd_idx;
    logic                                 subq_ready;
    logic                                 subq_locked;
    logic                                 subq_crc_good;
    logic                                 subq_irq_en;
    logic [CDD_TEXT_BYTES-1:0][7:0]       text_shadow;
    logic [CDD_TEXT_BYTES-1:0][7:0]       text_held;
    logic [CDD_TXI_W-1:0]                 text_rx_idx;
    logic [CDD_TXI_W-1:0]                 text_rd_idx;
    logic                                 text_ready_a;
    logic                                 text_locked;
    logic                                 text_active;
    logic                                 text_crc_good;
    logic                                 text_overrun;
    logic                                 text_freeze_en;
    logic                                 text_pass_bad_crc_en;
    logic                                 text_irq_en;
    cdd_mode_e                            mode;
    logic [CDD_FRM_W-1:0]                 wr_frm;
    logic [CDD_BYT_W-1:0]                 wr_idx;
    logic [CDD_FRM_W-1:0]                 rd_frm;
    logic [CDD_BYT_W-1:0]                 rd_idx;
    logic [CDD_FILL_W-1:0]                fill;
    logic                                 out_valid;
    logic                                 irq;
  } cdd_state_s;

endpackage

// ---- design/cdd_decoder.sv ----
// module: subcode/text capture, circ correction fifo and axi4-lite registers
//
// The AXI4-Lite slave port and the address map are this design's own decisions.

// Operation
// - capture subcode and text packs from the stream for register readback
// - status read finding subcode ready locks buffer and sets locked bit
// - subcode status shows crc result of the held frame
// - each subcode byte read returns next byte, at most ten
// - subcode bytes come out in frame order, ten bytes
// - subcode release read unlocks buffer for new capture
// - new subcode frame raises interrupt when its enable is set and the buffer is not locked
// - text buffer holds one pack while receiving the next
// - freeze bit decides whether held pack is protected during readback
// - pass-bad-crc bit decides whether failed packs are offered
// - text status read finding ready locks buffer when freeze set
// - text status shows crc result of the held pack
// - each text byte read returns next pack byte, at most sixteen
// - text release read unlocks buffer for new capture
// - unfrozen overwrite before full readback sets overrun, seen on release
// - new text pack raises interrupt when its enable is set and no readback is active
// - first stage fixes two errors, else adds one erasure to the second stage count
// - second stage fixes two errors or four erasures, else erased
// - flush mode clears pointers, writes nothing, corrects nothing, outputs nothing
// - play mode fills tables, corrects, outputs once fill level exceeds the latency
// - output waits for a 118-frame de-interleave latency
// - fill level readable, capped at 128 frames
module cdd_decoder
  import cdd_pkg::*;
#(
  parameter int LAT_FRAMES  = CDD_LAT_FRAMES,
  parameter int FIFO_FRAMES = CDD_FIFO_FRAMES
) (
  // clock, reset, enable
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic                  aclk_en,
  // axi4-lite write
  input  wire logic                  awvalid,
  output      logic                  awready,
  input  wire logic [CDD_ADDR_W-1:0] awaddr,
  input  wire logic [2:0]            awprot,
  input  wire logic                  wvalid,
  output      logic                  wready,
  input  wire logic [31:0]           wdata,
  input  wire logic [3:0]            wstrb,
  output      logic                  bvalid,
  input  wire logic                  bready,
  output      logic [1:0]            bresp,
  // axi4-lite read
  input  wire logic                  arvalid,
  output      logic                  arready,
  input  wire logic [CDD_ADDR_W-1:0] araddr,
  input  wire logic [2:0]            arprot,
  output      logic                  rvalid,
  input  wire logic                  rready,
  output      logic [31:0]           rdata,
  output      logic [1:0]            rresp,
  // demodulator side
  input  wire cdd_sym_in_s           subq_in,
  input  wire cdd_sym_in_s           text_in,
  input  wire cdd_data_in_s          data_in,
  // audio output side
  output      cdd_audio_out_s        audio_out,
  input  wire logic                  audio_ready,
  // interrupt
  output      logic                  irq
);

  // ==========================================================================
  // state
  localparam cdd_state_s RST = '{
    awready: 1'b1, wready: 1'b1, arready: 1'b1,
    bresp: CDD_RESP_OKAY, rresp: CDD_RESP_OKAY,
    mode: CDD_FLUSH, default: '0};

  cdd_state_s s;
  cdd_state_s next_s;
  logic [7:0] mem [(2**CDD_FRM_W)*(2**CDD_BYT_W)];
  logic       flag_mem [2**CDD_FRM_W];
  logic [7:0] out_byte;
  logic       out_flag;
  logic       subq_rel;
  logic       text_rel;
  logic       rd_fire;
  logic       c1_fail;
  logic [3:0] eras_total;
  logic       c2_fail;
  logic       mem_we;
  logic       flag_we;
  logic       mem_re;
  logic       fill_inc;
  logic       fill_dec;
  logic       text_take;

  assign rd_fire = aclk_en && arvalid && s.arready;

  // ==========================================================================
  // correction stages
  assign c1_fail = data_in.c1_errs > 3'(CDD_C1_MAX_ERR);
  assign eras_total = {1'b0, data_in.c2_eras} + {3'h0, c1_fail};
  assign c2_fail = (data_in.c2_errs > 3'(CDD_C2_MAX_ERR)) &&
                   (eras_total > 4'(CDD_C2_MAX_ERAS));
  assign text_take = text_in.crc_ok || s.text_pass_bad_crc_en;

  // ==========================================================================
  // next state
  always_comb begin
    next_s = s;
    subq_rel = 1'b0;
    text_rel = 1'b0;
    mem_we = 1'b0;
    flag_we = 1'b0;
    mem_re = 1'b0;
    fill_inc = 1'b0;
    fill_dec = 1'b0;
    // bus write
    if (awvalid && s.awready) begin
      next_s.aw_got = 1'b1;
      next_s.awaddr = awaddr;
      next_s.awready = 1'b0;
    end
    if (wvalid && s.wready) begin
      next_s.w_got = 1'b1;
      next_s.wdata = wdata;
      next_s.wstrb0 = wstrb[0];
      next_s.wready = 1'b0;
    end
    if (s.aw_got && s.w_got) begin
      next_s.aw_got = 1'b0;
      next_s.w_got = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = CDD_RESP_OKAY;
      unique case (s.awaddr)
        CDD_TEXT_CTRL_REG: begin
          if (s.wstrb0) begin
            next_s.text_freeze_en = s.wdata[CDD_FREEZE_BIT];
            next_s.text_pass_bad_crc_en = s.wdata[CDD_PASS_BIT];
          end
        end
        CDD_IRQ_ENABLE_REG_A: begin
          if (s.wstrb0) next_s.text_irq_en = s.wdata[CDD_IRQ_EN_BIT];
        end
        CDD_IRQ_ENABLE_REG_B: begin
          if (s.wstrb0) next_s.subq_irq_en = s.wdata[CDD_IRQ_EN_BIT];
        end
        CDD_DECODE_MODE_REG: begin
          if (s.wstrb0) begin
            next_s.mode = s.wdata[CDD_PLAY_BIT] ? CDD_PLAY : CDD_FLUSH;
          end
        end
        CDD_SUBQ_STATUS_REG, CDD_SUBQ_BYTE_REG, CDD_SUBQ_RELEASE_REG,
        CDD_TEXT_STATUS_REG, CDD_TEXT_BYTE_REG, CDD_TEXT_RELEASE_REG,
        CDD_FIFO_LEVEL_REG: begin
        end
        default: next_s.bresp = CDD_RESP_SLVERR;
      endcase
    end
    if (s.bvalid && bready) begin
      next_s.bvalid = 1'b0;
      next_s.awready = 1'b1;
      next_s.wready = 1'b1;
    end
    // bus read, with read side effects
    if (s.rvalid && rready) begin
      next_s.rvalid = 1'b0;
      next_s.arready = 1'b1;
    end
    if (arvalid && s.arready) begin
      next_s.arready = 1'b0;
      next_s.rvalid = 1'b1;
      next_s.rresp = CDD_RESP_OKAY;
      next_s.rdata = '0;
      unique case (araddr)
        CDD_SUBQ_STATUS_REG: begin
          next_s.rdata[CDD_READY_BIT] = s.subq_ready;
          next_s.rdata[CDD_LOCKED_BIT] = s.subq_locked;
          next_s.rdata[CDD_CRC_BIT] = s.subq_crc_good;
          if (s.subq_ready && !s.subq_locked) begin
            next_s.subq_locked = 1'b1;
            next_s.subq_rd_idx = '0;
          end
        end
        CDD_SUBQ_BYTE_REG: begin
          if (s.subq_locked &&
              s.subq_rd_idx < CDD_SQI_W'(CDD_SUBQ_BYTES)) begin
            next_s.rdata[7:0] = s.subq_held[s.subq_rd_idx];
            next_s.subq_rd_idx = s.subq_rd_idx + 1'b1;
          end
        end
        CDD_SUBQ_RELEASE_REG: begin
          next_s.subq_locked = 1'b0;
          next_s.subq_ready = 1'b0;
          subq_rel = 1'b1;
        end
        CDD_TEXT_CTRL_REG: begin
          next_s.rdata[CDD_FREEZE_BIT] = s.text_freeze_en;
          next_s.rdata[CDD_PASS_BIT] = s.text_pass_bad_crc_en;
        end
        CDD_TEXT_STATUS_REG: begin
          next_s.rdata[CDD_READY_BIT] = s.text_ready_a;
          next_s.rdata[CDD_LOCKED_BIT] = s.text_locked;
          next_s.rdata[CDD_CRC_BIT] = s.text_crc_good;
          if (s.text_ready_a && !s.text_active) begin
            next_s.text_active = 1'b1;
            next_s.text_locked = s.text_freeze_en;
            next_s.text_rd_idx = '0;
          end
        end
        CDD_TEXT_BYTE_REG: begin
          if (s.text_active &&
              s.text_rd_idx < CDD_TXI_W'(CDD_TEXT_BYTES)) begin
            next_s.rdata[7:0] = s.text_held[s.text_rd_idx[3:0]];
            next_s.text_rd_idx = s.text_rd_idx + 1'b1;
          end
        end
        CDD_TEXT_RELEASE_REG: begin
          next_s.rdata[CDD_OVERRUN_BIT] = s.text_overrun;
          next_s.text_overrun = 1'b0;
          next_s.text_active = 1'b0;
          next_s.text_locked = 1'b0;
          next_s.text_ready_a = 1'b0;
          text_rel = 1'b1;
        end
        CDD_IRQ_ENABLE_REG_A: next_s.rdata[CDD_IRQ_EN_BIT] = s.text_irq_en;
        CDD_IRQ_ENABLE_REG_B: next_s.rdata[CDD_IRQ_EN_BIT] = s.subq_irq_en;
        CDD_DECODE_MODE_REG: begin
          next_s.rdata[CDD_PLAY_BIT] = (s.mode == CDD_PLAY);
        end
        CDD_FIFO_LEVEL_REG: next_s.rdata[CDD_FILL_W-1:0] = s.fill;
        default: next_s.rresp = CDD_RESP_SLVERR;
      endcase
    end
    // subcode capture; a new frame wins over a release in the same cycle
    if (subq_in.valid) begin
      if (s.subq_rx_idx < CDD_SQI_W'(CDD_SUBQ_BYTES)) begin
        next_s.subq_shadow[s.subq_rx_idx] = subq_in.data;
        next_s.subq_rx_idx = s.subq_rx_idx + 1'b1;
      end
      if (subq_in.last) begin
        next_s.subq_rx_idx = '0;
        if (!s.subq_locked || subq_rel) begin
          next_s.subq_held = next_s.subq_shadow;
          next_s.subq_ready = 1'b1;
          next_s.subq_crc_good = subq_in.crc_ok;
        end
      end
    end
    // text capture into shadow while held pack stays readable
    if (text_in.valid) begin
      if (s.text_rx_idx < CDD_TXI_W'(CDD_TEXT_BYTES)) begin
        next_s.text_shadow[s.text_rx_idx[3:0]] = text_in.data;
        next_s.text_rx_idx = s.text_rx_idx + 1'b1;
      end
      if (text_in.last) begin
        next_s.text_rx_idx = '0;
        if (text_take && (!s.text_locked || text_rel)) begin
          next_s.text_held = next_s.text_shadow;
          next_s.text_ready_a = 1'b1;
          next_s.text_crc_good = text_in.crc_ok;
          if (s.text_active && !text_rel &&
              s.text_rd_idx < CDD_TXI_W'(CDD_TEXT_BYTES)) begin
            next_s.text_overrun = 1'b1;
          end
        end
      end
    end
    // main data fifo
    if (s.mode == CDD_PLAY) begin
      if (data_in.valid && s.fill < CDD_FILL_W'(FIFO_FRAMES)) begin
        mem_we = s.wr_idx < CDD_BYT_W'(CDD_FRAME_BYTES);
        if (mem_we) next_s.wr_idx = s.wr_idx + 1'b1;
        if (data_in.last) begin
          flag_we = 1'b1;
          fill_inc = 1'b1;
          next_s.wr_idx = '0;
          next_s.wr_frm = s.wr_frm + 1'b1;
        end
      end
      if (s.out_valid && audio_ready) next_s.out_valid = 1'b0;
      if (s.fill > CDD_FILL_W'(LAT_FRAMES) &&
          (!s.out_valid || audio_ready)) begin
        mem_re = 1'b1;
        next_s.out_valid = 1'b1;
        next_s.rd_idx = s.rd_idx + 1'b1;
        if (s.rd_idx == CDD_BYT_W'(CDD_FRAME_BYTES - 1)) begin
          next_s.rd_idx = '0;
          next_s.rd_frm = s.rd_frm + 1'b1;
          fill_dec = 1'b1;
        end
      end
      next_s.fill = s.fill + {7'h00, fill_inc} - {7'h00, fill_dec};
    end else begin
      next_s.wr_frm = '0;
      next_s.wr_idx = '0;
      next_s.rd_frm = '0;
      next_s.rd_idx = '0;
      next_s.fill = '0;
      next_s.out_valid = 1'b0;
    end
    next_s.irq = (next_s.subq_ready && !next_s.subq_locked &&
                  next_s.subq_irq_en) ||
                 (next_s.text_ready_a && !next_s.text_active &&
                  next_s.text_irq_en);
  end

  // ==========================================================================
  // registers and memory
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= RST;
    end else if (aclk_en) begin
      s <= next_s;
    end
  end

  always_ff @(posedge aclk) begin
    if (aclk_en && mem_we) begin
      mem[{s.wr_frm, s.wr_idx}] <= data_in.data;
    end
    if (aclk_en && flag_we) begin
      flag_mem[s.wr_frm] <= c2_fail;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_byte <= '0;
      out_flag <= 1'b0;
    end else if (aclk_en && mem_re) begin
      out_byte <= mem[{s.rd_frm, s.rd_idx}];
      out_flag <= flag_mem[s.rd_frm];
    end
  end

  // ==========================================================================
  // outputs
  assign awready = s.awready;
  assign wready = s.wready;
  assign bvalid = s.bvalid;
  assign bresp = s.bresp;
  assign arready = s.arready;
  assign rvalid = s.rvalid;
  assign rdata = s.rdata;
  assign rresp = s.rresp;
  assign irq = s.irq;
  assign audio_out = '{valid: s.out_valid, data: out_byte, erasure: out_flag};

  // ==========================================================================
  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_subq_lock_ready: assert property (
    rd_fire && araddr == CDD_SUBQ_STATUS_REG && s.subq_ready |=> s.subq_locked)
    else $error("subcode not locked after ready status read");
  a_subq_idle_read: assert property (
    rd_fire && araddr == CDD_SUBQ_STATUS_REG && !s.subq_ready &&
    !s.subq_locked |=> !s.subq_locked)
    else $error("subcode locked by status read with ready low");
  a_subq_frozen: assert property (
    aclk_en && s.subq_locked && !rd_fire |=> $stable(s.subq_held))
    else $error("locked subcode buffer changed");
  a_subq_byte_step: assert property (
    rd_fire && araddr == CDD_SUBQ_BYTE_REG && s.subq_locked &&
    s.subq_rd_idx == 4'h0 ##1 s.rvalid |-> s.rdata[7:0] == s.subq_held[0])
    else $error("first subcode byte wrong");
  a_text_lock: assert property (
    rd_fire && araddr == CDD_TEXT_STATUS_REG && s.text_ready_a &&
    !s.text_active |=> s.text_locked == $past(s.text_freeze_en))
    else $error("text lock does not follow freeze");
  a_text_drop_bad: assert property (
    aclk_en && text_in.valid && text_in.last && !text_in.crc_ok &&
    !s.text_pass_bad_crc_en |=> $stable(s.text_held))
    else $error("bad crc pack was offered");
  a_text_overrun: assert property (
    aclk_en && text_in.valid && text_in.last && text_take && !s.text_locked &&
    s.text_active && !rd_fire && s.text_rd_idx < 5'h10 |=> s.text_overrun)
    else $error("overrun not flagged");
  a_subq_irq: assert property (
    aclk_en && subq_in.valid && subq_in.last && !s.subq_locked &&
    s.subq_irq_en && !rd_fire |=> s.irq) else $error("subcode irq missing");
  a_flush_quiet: assert property (
    aclk_en && s.mode == CDD_FLUSH |=> !s.out_valid && s.fill == 8'h00)
    else $error("flush mode not quiet");
  a_fill_cap: assert property (
    s.fill <= CDD_FILL_W'(FIFO_FRAMES))
    else $error("fill above physical maximum");
  a_latency_gate: assert property (
    mem_re |-> s.fill > CDD_FILL_W'(LAT_FRAMES))
    else $error("output before latency reached");

  c_subq_all_bytes: cover property (
    rd_fire && araddr == CDD_SUBQ_BYTE_REG && s.subq_rd_idx == 4'h9);
  c_text_overrun: cover property (s.text_overrun);
  c_audio_pop: cover property (s.out_valid && audio_ready);
  c_fifo_full: cover property (s.fill == CDD_FILL_W'(FIFO_FRAMES));

endmodule

// ---- dv/tb.sv ----
// testbench: register-level tests of the subcode, text and circ decoder
module tb
  import cdd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // signals
  logic aclk = 0, aresetn = 0, audio_ready = 0, aclk_en = 1;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [7:0]     awaddr = 0, araddr = 0;
  logic [31:0]    wdata = 0, rdata, d;
  logic [3:0]     wstrb = 4'hf;
  logic [1:0]     bresp, rresp, rs;
  cdd_sym_in_s    subq_in = '0, text_in = '0;
  cdd_data_in_s   data_in = '0;
  cdd_audio_out_s audio_out;
  int             err_total = 0, n_compared = 0, k;
  cdd_decoder #(.LAT_FRAMES(2), .FIFO_FRAMES(4)) DUT (
    .aclk, .aresetn, .aclk_en, .awvalid, .awready, .awaddr,
    .awprot(3'h0), .wvalid, .wready, .wdata, .wstrb, .bvalid,
    .bready, .bresp, .arvalid, .arready, .araddr, .arprot(3'h0),
    .rvalid, .rready, .rdata, .rresp, .subq_in, .text_in, .data_in,
    .audio_out, .audio_ready, .irq);
  initial begin
    forever #5 aclk = ~aclk;
  end
  // ==========================================================================
  // tasks
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("wrong value at %0t: got %h, expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    rs = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    d = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(d, e);
  endtask
  task automatic sym(input bit t, input int n, input logic c,
                     input logic [7:0] b);
    cdd_sym_in_s s;
    for (int i = 0; i < n; i++) begin
      @(posedge aclk);
      s = '{1'b1, b + 8'(i), i == n - 1, c};
      if (t) text_in <= s;
      else subq_in <= s;
    end
    @(posedge aclk);
    text_in <= '0;
    subq_in <= '0;
  endtask
  task automatic frm(input logic [7:0] b, input logic [2:0] e2, s2);
    for (int i = 0; i < 24; i++) begin
      @(posedge aclk);
      data_in <= '{1'b1, b + 8'(i), i == 23, 3'h0, e2, s2};
    end
    @(posedge aclk);
    data_in <= '0;
  endtask
  task automatic test_done;
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #300000;
    err_total++;
    test_done;
  end
  // ==========================================================================
  // tests
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rc(CDD_FIFO_LEVEL_REG, 32'h0);
    rc(CDD_TEXT_CTRL_REG, 32'h0);
    wstrb <= 4'he;
    wr(CDD_TEXT_CTRL_REG, 32'h3);
    chk(rs, CDD_RESP_OKAY);
    wstrb <= 4'hf;
    rc(CDD_TEXT_CTRL_REG, 32'h0);
    rd(8'h3C);
    chk(rs, CDD_RESP_SLVERR);
    wr(CDD_IRQ_ENABLE_REG_B, 32'h1);
    sym(0, 10, 1'b1, 8'h10);
    repeat (2) @(posedge aclk);
    chk(irq, 1);
    rc(CDD_SUBQ_STATUS_REG, 32'h5);
    rc(CDD_SUBQ_STATUS_REG, 32'h7);
    chk(irq, 0);
    sym(0, 10, 1'b1, 8'h40);
    for (int i = 0; i < 10; i++) rc(CDD_SUBQ_BYTE_REG, 32'h10 + i);
    rc(CDD_SUBQ_BYTE_REG, 32'h0);
    rc(CDD_SUBQ_RELEASE_REG, 32'h0);
    rd(CDD_SUBQ_STATUS_REG);
    chk(d[1:0], 2'h0);
    sym(0, 10, 1'b0, 8'h60);
    rc(CDD_SUBQ_STATUS_REG, 32'h1);
    rc(CDD_SUBQ_RELEASE_REG, 32'h0);
    aclk_en <= 1'b0;
    sym(0, 10, 1'b1, 8'h70);
    aclk_en <= 1'b1;
    rc(CDD_SUBQ_STATUS_REG, 32'h0);
    wr(CDD_IRQ_ENABLE_REG_A, 32'h1);
    sym(1, 16, 1'b0, 8'h80);
    rd(CDD_TEXT_STATUS_REG);
    chk(d[0], 1'b0);
    wr(CDD_TEXT_CTRL_REG, 32'h2);
    sym(1, 16, 1'b0, 8'h80);
    repeat (2) @(posedge aclk);
    chk(irq, 1);
    rc(CDD_TEXT_STATUS_REG, 32'h1);
    rc(CDD_TEXT_BYTE_REG, 32'h80);
    rc(CDD_TEXT_BYTE_REG, 32'h81);
    sym(1, 16, 1'b1, 8'hA0);
    rc(CDD_TEXT_RELEASE_REG, 32'h1);
    wr(CDD_TEXT_CTRL_REG, 32'h3);
    sym(1, 16, 1'b1, 8'hC0);
    rc(CDD_TEXT_STATUS_REG, 32'h5);
    rc(CDD_TEXT_STATUS_REG, 32'h7);
    sym(1, 16, 1'b1, 8'hE0);
    for (int i = 0; i < 16; i++) rc(CDD_TEXT_BYTE_REG, 32'hC0 + i);
    rc(CDD_TEXT_RELEASE_REG, 32'h0);
    sym(1, 16, 1'b1, 8'h20);
    rc(CDD_TEXT_STATUS_REG, 32'h5);
    wr(CDD_DECODE_MODE_REG, 32'h1);
    frm(8'h00, 3'h3, 3'h5);
    frm(8'h30, 3'h0, 3'h0);
    rc(CDD_FIFO_LEVEL_REG, 32'h2);
    chk(audio_out.valid, 1'b0);
    frm(8'h60, 3'h0, 3'h0);
    repeat (3) @(posedge aclk);
    chk(audio_out, {1'b1, 8'h00, 1'b1});
    audio_ready <= 1'b1;
    k = 0;
    while (k < 24) begin
      @(posedge aclk);
      if (audio_out.valid && audio_ready) begin
        chk(audio_out.data, k);
        k++;
      end
    end
    rc(CDD_FIFO_LEVEL_REG, 32'h2);
    chk(audio_out.valid, 1'b0);
    wr(CDD_DECODE_MODE_REG, 32'h0);
    rc(CDD_FIFO_LEVEL_REG, 32'h0);
    frm(8'h90, 3'h0, 3'h0);
    rc(CDD_FIFO_LEVEL_REG, 32'h0);
    test_done;
  end
endmodule
